/* File: verilog/io_port_consts.vh */
`ifndef IO_PORT_CONSTS_VH
`define IO_PORT_CONSTS_VH
// Register byte offsets
`define OFS_DATA_A     8'h00
`define OFS_DATA_B     8'h04
`define OFS_DATA_C     8'h08
`define OFS_DATA_D     8'h0C
`define OFS_DIR_A      8'h10
`define OFS_DIR_B      8'h14
`define OFS_DIR_C      8'h18
`define OFS_DIR_D      8'h1C
`define OFS_PU_A       8'h20
`define OFS_PU_B       8'h24
`define OFS_PU_C       8'h28
`define OFS_PU_D       8'h2C
`define OFS_WAKE_SEL   8'h30
`define OFS_MISC       8'h34
`define OFS_PERIPH     8'h38
`define OFS_CONV       8'h3C
`define OFS_BIT_OP     8'h40
`define OFS_IRQ_STAT   8'h44
`define OFS_IRQ_CLR    8'h48
`define OFS_IRQ_EN     8'h4C
// Reset values
`define RST_DATA       32'hFFFFFFFF
`define RST_DIR        32'hFFFFFFFF
`define RST_PU         32'h00000000
`define RST_BYTE       8'h00
// Misc register fields
`define MISC_OD_LSB    0
`define MISC_EXT_IRQ_LINE_0_EN   4
`define MISC_EXT_IRQ_LINE_1_EN   5
// Periph register fields
`define PER_PWM_LSB    0
`define PER_TMR_LSB    4
// Bit operation fields
`define BOP_BIT_LSB    0
`define BOP_PORT_LSB   3
`define BOP_SET        5
`define BOP_DIR        6
// Pin positions in the 32-bit pin vector
`define PIN_PFD        3
`define PIN_TMR_LSB    16
`define PIN_PWM_LSB    24
`define PIN_EXT_IRQ_LINE_0       28
`define PIN_EXT_IRQ_LINE_1       29
// Status bits
`define ST_WAKE        0
`define ST_EXT_IRQ_LINE_0        1
`define ST_EXT_IRQ_LINE_1        2
// Bus responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

/* File: verilog/io_port_block.v */
// Behaviour
// R01 - Direction bit 1 makes pin input; port read returns live pin level.
// R02 - Direction bit 0 makes pin push-pull output driving its data latch.
// R03 - Output pins read back their data latch, not the pin level.
// R04 - Input pins are not latched; read returns pin state directly.
// R05 - Port D bits 4,5 are external interrupt inputs unless their enables clear.
// R06 - Timer clock pin feeds timer only when selected and pin is input.
// R07 - Timer input pin stays readable as ordinary port input.
// R08 - Divider output on port A bit 3 when option set and pin output.
// R09 - Divider option with pin input leaves ordinary input with pull-high.
// R10 - PWM drives port D pin when enabled and pin set as output.
// R11 - PWM enabled with pin input leaves ordinary input with pull-high.
// R12 - Analog-selected port B pins lose pull-high; digital pins keep it.
// R13 - Reset sets all data latches and direction registers to ones.
// R14 - Software loads data latches before switching pins to output.
// R15 - Single-bit set or clear is read-modify-write of whole port.
// R16 - In power down, falling edge on selected port A pin wakes device.
// R17 - Pull-high connects only when selected and pin is input.
// R18 - Port A bits 0..3 become open-drain when their enables set.
// R19 - Pin inputs pass a two-flop synchroniser before any use.
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`include "io_port_consts.vh"

module io_port_block #(
   parameter PFD_OPTION = 1'b0
) (
   // Clock and reset
   input  wire        mclk,
   input  wire        rst_b,
   // AXI4-Lite write address
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [7:0]  s_axi_awaddr,
   // AXI4-Lite write data
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   // AXI4-Lite write response
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   output wire [1:0]  s_axi_bresp,
   // AXI4-Lite read address
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   input  wire [7:0]  s_axi_araddr,
   // AXI4-Lite read data
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   // Port pins: A[7:0], B[15:8], C[23:16], D[31:24]
   input  wire [31:0] pin_in,
   output wire [31:0] pin_out,
   output wire [31:0] pin_oe,
   output wire [31:0] pin_pullup_en,
   // Shared peripheral sources
   input  wire        freq_divider_output,
   input  wire [3:0]  pwm_in,
   // Shared peripheral sinks
   output wire        ext_irq_line_0,
   output wire        ext_irq_line_1,
   output wire [3:0]  timer_ext_clock,
   // Power down and wake
   input  wire        power_down,
   output wire        wake_req,
   // Interrupt
   output wire        irq
);

   reg  [31:0] sync1_q;
   reg  [31:0] sync2_q;
   reg  [31:0] prev_q;
   reg  [31:0] dir_q;
   reg  [31:0] lat_q;
   reg  [31:0] pu_q;
   reg  [7:0]  port_a_wake_select_q;
   reg  [7:0]  misc_q;
   reg  [7:0]  periph_q;
   reg  [7:0]  converter_control_q;
   reg  [2:0]  irq_en_q;
   reg  [2:0]  irq_st_q;
   reg  [31:0] out_q;
   reg  [31:0] oe_q;
   reg  [31:0] pu_en_q;
   reg  [3:0]  tmr_q;
   reg  [1:0]  ext_q;
   reg         wake_q;
   reg         aw_have_q;
   reg         w_have_q;
   reg  [7:0]  awaddr_q;
   reg  [31:0] wdata_q;
   reg         wstrb_q;
   reg         bvalid_q;
   reg  [1:0]  bresp_q;
   reg         rvalid_q;
   reg  [31:0] rdata_q;
   reg  [1:0]  rresp_q;

   wire [3:0]  open_drain_enables = misc_q[`MISC_OD_LSB +: 4];
   wire [1:0]  irq_enable_control = {misc_q[`MISC_EXT_IRQ_LINE_1_EN], misc_q[`MISC_EXT_IRQ_LINE_0_EN]};
   wire [31:0] fall = prev_q & ~sync2_q;
   wire [31:0] int_mask = {2'b00, irq_enable_control, 28'h0000000};
   wire [31:0] in_mask = dir_q | int_mask;
   wire [31:0] port_read;
   wire [31:0] drv_val;
   wire [31:0] drv_en;
   wire [31:0] pu_val;
   wire [2:0]  irq_ev;
   wire        do_wr = aw_have_q & w_have_q;
   wire [1:0]  bop_port = wdata_q[`BOP_PORT_LSB +: 2];
   wire [2:0]  bop_bit = wdata_q[`BOP_BIT_LSB +: 3];
   reg         wr_ok;
   reg  [31:0] rd_val;
   reg         rd_ok;
   reg  [7:0]  bop_byte;

   // R19 two-flop sync
   always @(posedge mclk) begin
      if (!rst_b) begin
         sync1_q <= 32'hFFFFFFFF;
         sync2_q <= 32'hFFFFFFFF;
         prev_q  <= 32'hFFFFFFFF;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // R01 input direction reads pin
   // R03 outputs read latch
   // R04 inputs not latched
   // R07 shared inputs stay readable
   assign port_read = (in_mask & sync2_q) | (~in_mask & lat_q);

   // R02 latch drives outputs
   // R08 divider on A3
   // R10 PWM on D0..D3
   assign drv_val = {lat_q[31:28],
                     (periph_q[`PER_PWM_LSB +: 4] & pwm_in) | (~periph_q[`PER_PWM_LSB +: 4] & lat_q[27:24]),
                     lat_q[23:4],
                     PFD_OPTION ? freq_divider_output : lat_q[`PIN_PFD],
                     lat_q[2:0]};

   // R05 interrupt pins undriven
   // R09 divider yields to input
   // R11 PWM yields to input
   // R18 open drain on A0..A3
   assign drv_en = ~in_mask & {28'hFFFFFFF, ~(open_drain_enables & drv_val[3:0])};

   // R12 analog pins unpulled
   // R17 pull only on inputs
   assign pu_val = pu_q & in_mask & ~{16'h0000, converter_control_q, 8'h00};

   // R16 wake on selected falls
   // R05 interrupt line edges
   assign irq_ev = {irq_enable_control[1] & fall[`PIN_EXT_IRQ_LINE_1],
                    irq_enable_control[0] & fall[`PIN_EXT_IRQ_LINE_0],
                    power_down & (|(fall[7:0] & port_a_wake_select_q))};

   always @(posedge mclk) begin
      if (!rst_b) begin
         out_q   <= `RST_DATA;
         oe_q    <= 32'h00000000;
         pu_en_q <= 32'h00000000;
         tmr_q   <= 4'h0;
         ext_q   <= 2'h0;
         wake_q  <= 1'b0;
      end else begin
         out_q   <= drv_val;
         oe_q    <= drv_en;
         pu_en_q <= pu_val;
         // R06 timer clock gating
         tmr_q   <= sync2_q[`PIN_TMR_LSB +: 4] & periph_q[`PER_TMR_LSB +: 4] & dir_q[`PIN_TMR_LSB +: 4];
         // R05 interrupt line routing
         ext_q   <= {sync2_q[`PIN_EXT_IRQ_LINE_1], sync2_q[`PIN_EXT_IRQ_LINE_0]} & irq_enable_control;
         wake_q  <= irq_ev[`ST_WAKE];
      end
   end

   assign pin_out         = out_q;
   assign pin_oe          = oe_q;
   assign pin_pullup_en   = pu_en_q;
   assign timer_ext_clock = tmr_q;
   assign ext_irq_line_0  = ext_q[0];
   assign ext_irq_line_1  = ext_q[1];
   assign wake_req        = wake_q;
   assign irq             = |(irq_st_q & irq_en_q);

   // Bus handshakes
   assign s_axi_awready = ~aw_have_q & ~bvalid_q;
   assign s_axi_wready  = ~w_have_q & ~bvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   // Write address decode
   always @* begin
      case (awaddr_q)
         `OFS_DATA_A, `OFS_DATA_B, `OFS_DATA_C, `OFS_DATA_D,
         `OFS_DIR_A, `OFS_DIR_B, `OFS_DIR_C, `OFS_DIR_D,
         `OFS_PU_A, `OFS_PU_B, `OFS_PU_C, `OFS_PU_D,
         `OFS_WAKE_SEL, `OFS_MISC, `OFS_PERIPH, `OFS_CONV,
         `OFS_BIT_OP, `OFS_IRQ_CLR, `OFS_IRQ_EN, `OFS_IRQ_STAT: wr_ok = 1'b1;
         default: wr_ok = 1'b0;
      endcase
   end

   // R15 bit op reads whole port then sets or clears one bit
   always @* begin
      bop_byte = wdata_q[`BOP_DIR] ? dir_q[8 * bop_port +: 8] : port_read[8 * bop_port +: 8];
      bop_byte[bop_bit] = wdata_q[`BOP_SET];
   end

   always @(posedge mclk) begin
      if (!rst_b) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb[0];
         end
         // Response waits for address and data
         if (do_wr) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // Register file
   always @(posedge mclk) begin
      if (!rst_b) begin
         // R13 ports start as inputs with latches high
         lat_q                <= `RST_DATA;
         dir_q                <= `RST_DIR;
         pu_q                 <= `RST_PU;
         port_a_wake_select_q <= `RST_BYTE;
         misc_q               <= `RST_BYTE;
         periph_q             <= `RST_BYTE;
         converter_control_q  <= `RST_BYTE;
         irq_en_q             <= 3'h0;
         irq_st_q             <= 3'h0;
      end else begin
         // Set wins over clear
         irq_st_q <= (irq_st_q & ~((do_wr && wstrb_q && awaddr_q == `OFS_IRQ_CLR) ? wdata_q[2:0] : 3'h0))
                     | irq_ev;
         if (do_wr && wstrb_q) begin
            case (awaddr_q)
               `OFS_DATA_A:   lat_q[7:0]   <= wdata_q[7:0];
               `OFS_DATA_B:   lat_q[15:8]  <= wdata_q[7:0];
               `OFS_DATA_C:   lat_q[23:16] <= wdata_q[7:0];
               `OFS_DATA_D:   lat_q[31:24] <= wdata_q[7:0];
               `OFS_DIR_A:    dir_q[7:0]   <= wdata_q[7:0];
               `OFS_DIR_B:    dir_q[15:8]  <= wdata_q[7:0];
               `OFS_DIR_C:    dir_q[23:16] <= wdata_q[7:0];
               `OFS_DIR_D:    dir_q[31:24] <= wdata_q[7:0];
               `OFS_PU_A:     pu_q[7:0]    <= wdata_q[7:0];
               `OFS_PU_B:     pu_q[15:8]   <= wdata_q[7:0];
               `OFS_PU_C:     pu_q[23:16]  <= wdata_q[7:0];
               `OFS_PU_D:     pu_q[31:24]  <= wdata_q[7:0];
               `OFS_WAKE_SEL: port_a_wake_select_q <= wdata_q[7:0];
               `OFS_MISC:     misc_q <= wdata_q[7:0];
               `OFS_PERIPH:   periph_q <= wdata_q[7:0];
               `OFS_CONV:     converter_control_q <= wdata_q[7:0];
               `OFS_IRQ_EN:   irq_en_q <= wdata_q[2:0];
               // R15 write back modified byte
               `OFS_BIT_OP: begin
                  if (wdata_q[`BOP_DIR])
                     dir_q[8 * bop_port +: 8] <= bop_byte;
                  else
                     lat_q[8 * bop_port +: 8] <= bop_byte;
               end
               default: ;
            endcase
         end
      end
   end

   // Read decode
   always @* begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         // R01 R03 R04 port reads
         `OFS_DATA_A:   rd_val = {24'h000000, port_read[7:0]};
         `OFS_DATA_B:   rd_val = {24'h000000, port_read[15:8]};
         `OFS_DATA_C:   rd_val = {24'h000000, port_read[23:16]};
         `OFS_DATA_D:   rd_val = {24'h000000, port_read[31:24]};
         `OFS_DIR_A:    rd_val = {24'h000000, dir_q[7:0]};
         `OFS_DIR_B:    rd_val = {24'h000000, dir_q[15:8]};
         `OFS_DIR_C:    rd_val = {24'h000000, dir_q[23:16]};
         `OFS_DIR_D:    rd_val = {24'h000000, dir_q[31:24]};
         `OFS_PU_A:     rd_val = {24'h000000, pu_q[7:0]};
         `OFS_PU_B:     rd_val = {24'h000000, pu_q[15:8]};
         `OFS_PU_C:     rd_val = {24'h000000, pu_q[23:16]};
         `OFS_PU_D:     rd_val = {24'h000000, pu_q[31:24]};
         `OFS_WAKE_SEL: rd_val = {24'h000000, port_a_wake_select_q};
         `OFS_MISC:     rd_val = {24'h000000, misc_q};
         `OFS_PERIPH:   rd_val = {24'h000000, periph_q};
         `OFS_CONV:     rd_val = {24'h000000, converter_control_q};
         `OFS_IRQ_STAT: rd_val = {29'h00000000, irq_st_q};
         `OFS_IRQ_EN:   rd_val = {29'h00000000, irq_en_q};
         `OFS_BIT_OP, `OFS_IRQ_CLR: rd_val = 32'h00000000;
         default: begin
            rd_val = 32'h00000000;
            rd_ok  = 1'b0;
         end
      endcase
   end

   always @(posedge mclk) begin
      if (!rst_b) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_val;
         rresp_q  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

endmodule // io_port_block

/* File: sim/io_port_properties.sv */
module io_port_checker #(
   parameter PFD_OPTION = 1'b0
) (
   // Clock and reset
   input wire        mclk,
   input wire        rst_b,
   // Bus handshakes
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   // Pins and shared functions
   input wire [31:0] pin_in,
   input wire [31:0] pin_out,
   input wire [31:0] pin_oe,
   input wire [31:0] pin_pullup_en,
   input wire        freq_divider_output,
   input wire        ext_irq_line_0,
   input wire [3:0]  timer_ext_clock,
   input wire        power_down,
   input wire        wake_req
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence s_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_wake_lone;
      wake_req && $past(pin_in[7:0]) == $past(pin_in[7:0], 2);
   endsequence
   sequence s_pulse_end;
      ##1 !wake_req;
   endsequence
   AST_RST_STATE: assert property ($rose(rst_b) |-> pin_oe == 32'h0 && pin_out == 32'hFFFFFFFF)
      else $error("pins not idle after reset");
   AST_PULLUP_INPUT: assert property ((pin_pullup_en & pin_oe) == 32'h0)
      else $error("pull-high on a driven pin");
   AST_PFD_ROUTE: assert property (PFD_OPTION && pin_oe[3] |-> pin_out[3] == $past(freq_divider_output))
      else $error("divider not on driven pin");
   AST_TIMER_SRC: assert property (timer_ext_clock[0] |-> $past(pin_in[16], 3))
      else $error("timer input without pin level");
   AST_EXTIRQ_SRC: assert property (ext_irq_line_0 |-> $past(pin_in[28], 3))
      else $error("interrupt line without pin level");
   AST_WAKE_PULSE: assert property (s_wake_lone |-> s_pulse_end)
      else $error("wake pulse too long");
   AST_WAKE_PD: assert property (wake_req |-> $past(power_down))
      else $error("wake outside power down");
   AST_READ_ANSWER: assert property (s_ar_taken |=> s_axi_rvalid)
      else $error("read not answered");
   AST_WRITE_RETIRE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response held");
   AST_WRITE_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken during response");
endmodule // io_port_checker

bind io_port_block io_port_checker #(.PFD_OPTION(PFD_OPTION)) io_port_checker_i (.mclk, .rst_b, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .pin_in, .pin_out,
   .pin_oe, .pin_pullup_en, .freq_divider_output, .ext_irq_line_0, .timer_ext_clock, .power_down, .wake_req);

/* File: sim/pin_partner.sv */
module pin_partner (
   // Device side
   input  wire        mclk,
   input  wire [31:0] pin_out,
   input  wire [31:0] pin_oe,
   input  wire [31:0] pin_pullup_en,
   // Outside drivers
   input  wire [31:0] ext_drive,
   input  wire [31:0] ext_en,
   output wire [31:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] float_q = 32'h0;
   // Unheld, unpulled lines wander each cycle
   always @(posedge mclk) float_q <= ~float_q;
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_drive) | (~ext_en & (pin_pullup_en | float_q))));
endmodule // pin_partner

/* File: sim/io_port_block_tb_top.sv */
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module io_port_block_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 1'b0, rst_b = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1, freq_divider_output = 1'b0, power_down = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, ext_drive = 32'h0, ext_en = 32'hFFFFFFFF;
   logic [3:0]  pwm_in = 4'h0, s_axi_wstrb = 4'hF;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_req, irq;
   wire         ext_irq_line_0, ext_irq_line_1;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire [3:0]   timer_ext_clock;
   wire [31:0]  s_axi_rdata, pin_in, pin_out, pin_oe, pin_pullup_en;
   int          err_count = 0, checked = 0, cyc = 0;
   io_port_block #(.PFD_OPTION(1'b1)) io_port_block_i (.mclk, .rst_b, .s_axi_awvalid, .s_axi_awready,
      .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .pin_in, .pin_out, .pin_oe, .pin_pullup_en, .freq_divider_output, .pwm_in, .ext_irq_line_0,
      .ext_irq_line_1, .timer_ext_clock, .power_down, .wake_req, .irq);
   pin_partner pin_partner_i (.mclk, .pin_out, .pin_oe, .pin_pullup_en, .ext_drive, .ext_en, .pin_in);
   always #5 mclk = ~mclk;
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
      logic ta, tw, tb;
      logic [1:0] r;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(negedge mclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge mclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (!tb);
      `CHK(r, er)
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er = 2'h0);
      logic ta, tr;
      logic [1:0] r;
      logic [31:0] d;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(negedge mclk);
         ta = s_axi_arvalid & s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge mclk);
         if (ta) s_axi_arvalid <= 1'b0;
      end while (!tr);
      `CHK(d, {24'h0, exp})
      `CHK(r, er)
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic done(input string s);
      $display("end of %s: %0d checks, %0d mismatches", s, checked, err_count);
   endtask
   function automatic logic [7:0] mix(input logic [7:0] lat, input logic [7:0] dir, input logic [7:0] pins);
      return (lat & ~dir) | (pins & dir);
   endfunction
   task automatic summarize();
      $display("totals: %0d checks, %0d mismatches", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         summarize();
      end
   end
   initial begin
      logic [7:0] v, d, e, x;
      int p, n;
      void'($urandom(54));
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      idle(0);
      `CHK({pin_oe, pin_out}, {32'h0, 32'hFFFFFFFF})
      for (p = 0; p < 4; p++)
         rd(8'(16 + 4 * p), 8'hFF);
      wr(8'h14, 8'h00);
      idle(5);
      `CHK({pin_oe[15:8], pin_out[15:8]}, 16'hFFFF)
      done("reset");
      for (int i = 0; i < 24; i++) begin
         p = $urandom_range(3);
         {v, d, e} = 24'($urandom);
         x = v;
         if (p == 0) x[3] = ~v[3];
         @(posedge mclk);
         ext_drive[8 * p +: 8] <= e;
         freq_divider_output <= ~v[3];
         wr(8'(4 * p), v);
         wr(8'(16 + 4 * p), d);
         idle(5);
         `CHK(pin_oe[8 * p +: 8], ~d)
         `CHK(pin_out[8 * p +: 8] & ~d, x & ~d)
         rd(8'(4 * p), mix(v, d, e));
      end
      done("random ports");
      wr(8'h38, 8'hF0);
      wr(8'h18, 8'hFF);
      for (int k = 0; k < 2; k++) begin
         e = k ? 8'hA5 : 8'h5A;
         @(posedge mclk);
         ext_drive[23:16] <= e;
         idle(5);
         rd(8'h08, e);
         `CHK(timer_ext_clock, e[3:0])
      end
      wr(8'h18, 8'hFE);
      idle(5);
      `CHK(timer_ext_clock, 4'h4)
      done("timer input");
      {v, e} = 16'($urandom);
      @(posedge mclk);
      ext_drive[15:8] <= e;
      wr(8'h04, v);
      wr(8'h14, 8'h0F);
      idle(4);
      wr(8'h40, 8'h2E);
      wr(8'h14, 8'h00);
      idle(5);
      x = mix(v, 8'h0F, e);
      x[6] = 1'b1;
      `CHK(pin_out[15:8], x)
      wr(8'h40, 8'h68);
      rd(8'h14, 8'h01);
      done("bit operations");
      wr(8'h24, 8'hFF);
      wr(8'h14, 8'hF0);
      wr(8'h3C, 8'h30);
      idle(3);
      `CHK(pin_pullup_en[15:8], 8'hC0)
      @(posedge mclk);
      ext_en[15:14] <= 2'h0;
      idle(3);
      rd(8'h04, mix(x, 8'hF0, {2'h3, e[5:0]}));
      done("pull-high");
      @(posedge mclk);
      ext_drive[29:28] <= 2'h3;
      wr(8'h34, 8'h30);
      wr(8'h1C, 8'h00);
      wr(8'h4C, 8'h02);
      idle(5);
      `CHK({pin_oe[29:28], ext_irq_line_1, ext_irq_line_0, irq}, 5'h06)
      @(posedge mclk);
      ext_drive[28] <= 1'b0;
      idle(6);
      `CHK({ext_irq_line_0, irq}, 2'h1)
      wr(8'h4C, 8'h00);
      idle(1);
      `CHK(irq, 1'b0)
      wr(8'h4C, 8'h02);
      wr(8'h48, 8'h02);
      idle(1);
      `CHK(irq, 1'b0)
      rd(8'h44, 8'h00);
      done("external interrupt");
      wr(8'h10, 8'hFF);
      wr(8'h30, 8'h01);
      wr(8'h4C, 8'h01);
      @(posedge mclk);
      ext_drive[1:0] <= 2'h3;
      power_down <= 1'b1;
      idle(5);
      for (int k = 1; k >= 0; k--) begin
         @(posedge mclk);
         ext_drive[k] <= 1'b0;
         n = 0;
         repeat (10) begin
            @(negedge mclk);
            if (wake_req !== 1'b0) n++;
         end
         `CHK(n, 1 - k)
      end
      `CHK(irq, 1'b1)
      rd(8'h44, 8'h01);
      done("wake");
      wr(8'h38, 8'h01);
      wr(8'h0C, 8'h00);
      wr(8'h1C, 8'hFE);
      @(posedge mclk);
      pwm_in <= 4'h1;
      idle(3);
      `CHK({pin_oe[24], pin_out[24]}, 2'h3)
      rd(8'h0C, mix(8'h00, 8'hFE, ext_drive[31:24]));
      wr(8'h1C, 8'hFF);
      idle(3);
      `CHK(pin_oe[24], 1'b0)
      wr(8'h34, 8'h01);
      wr(8'h10, 8'hFE);
      for (int k = 0; k < 2; k++) begin
         wr(8'h00, 8'(k));
         idle(3);
         `CHK({pin_oe[0], pin_out[0] & pin_oe[0]}, {~k[0], 1'b0})
      end
      @(posedge mclk);
      s_axi_wstrb <= 4'h0;
      wr(8'h00, 8'h00);
      s_axi_wstrb <= 4'hF;
      idle(3);
      `CHK(pin_oe[0], 1'b0)
      wr(8'h80, 8'h55, 2'h2);
      rd(8'h80, 8'h00, 2'h2);
      done("shared outputs");
      summarize();
   end
endmodule // io_port_block_tb_top
